// ===== hdl/eorm_pkg.sv
// Constants and types for the E3 receive overhead monitor register bank.
// Assumes a single 200 MHz clock shared with the port framer and an APB master.
package eorm_pkg;

  localparam int unsigned APB_ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 16;
  localparam int unsigned IDX_W = 6;

  // Register indices; the byte address on APB is four times the index
  localparam logic [5:0] IDX_LATCHED = 6'h2A;
  localparam logic [5:0] IDX_IRQ_EN2 = 6'h2E;
  localparam logic [5:0] IDX_MA_INFO = 6'h30;
  localparam logic [5:0] IDX_NR_GC = 6'h32;
  localparam logic [5:0] IDX_FRAME_CNT = 6'h34;
  localparam logic [5:0] IDX_PARITY_CNT = 6'h36;
  localparam logic [5:0] IDX_REMOTE_CNT = 6'h38;
  localparam logic [5:0] IDX_CONTROL = 6'h3A;

  // Bit positions shared by the latched flags and their enables, then the control bit
  localparam int unsigned BIT_REMOTE_ERR = 10;
  localparam int unsigned BIT_PARITY_ERR = 9;
  localparam int unsigned BIT_FRAME_ERR = 8;
  localparam int unsigned BIT_REMOTE_CNT = 2;
  localparam int unsigned BIT_PARITY_CNT = 1;
  localparam int unsigned BIT_FRAME_CNT = 0;
  localparam logic [15:0] FLAG_MASK = 16'h0707;
  localparam int unsigned BIT_TI_EXTRACT = 0;

  // Field positions inside the read words and the received MA byte
  localparam int unsigned PT_LSB = 4;
  localparam int unsigned GC_LSB = 8;
  localparam int unsigned MA_PT_LSB = 3;

  // Counter slots
  localparam int unsigned CNT_FRAME = 0;
  localparam int unsigned CNT_PARITY = 1;
  localparam int unsigned CNT_REMOTE = 2;

  // Reset values and the counter saturation limit
  localparam logic [15:0] IRQ_EN_RST = 16'h0000;
  localparam logic [15:0] LATCHED_RST = 16'h0000;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  // Frames of identical value needed before an overhead value is accepted
  localparam int unsigned INTEG_FRAMES = 3;
  localparam logic [1:0] INTEG_LAST = 2'(INTEG_FRAMES - 1);
  localparam logic [1:0] TI_LAST_PHASE = 2'h3;

  typedef struct packed {
    logic [7:0] pres;
    logic [7:0] cand;
    logic [1:0] cnt;
  } eorm_integ_t;

endpackage

// ===== hdl/eorm_rx_ovh_regs.sv
// Per-port receive overhead monitor: latched error flags, their interrupt
// enables, integrated MA/NR/GC overhead and three error counters over APB.
// Assumes framer strobes and perf_monitor_update are on ref_clk, one cycle each.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps

module eorm_rx_ovh_regs
  import eorm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frame_valid,
  input wire logic [7:0] ma_byte,
  input wire logic [7:0] nr_byte,
  input wire logic [7:0] gc_byte,
  input wire logic frame_err_evt,
  input wire logic parity_err_evt,
  input wire logic remote_err_evt,
  input wire logic perf_monitor_update,
  input wire logic global_port_irq_enable,
  output logic irq_req
);

  typedef struct packed {
    logic [15:0] irq_en;
    logic [15:0] latched;
    logic ti_extract_en;
    logic [2:0][15:0] acc;
    logic [2:0][15:0] count;
    eorm_integ_t pt;
    eorm_integ_t ti;
    eorm_integ_t nr;
    eorm_integ_t gc;
    logic [3:0] ti_shift;
    logic [1:0] ti_phase;
    logic [DATA_W-1:0] rdata;
    logic slverr;
  } eorm_state_t;

  eorm_state_t st_q;
  eorm_state_t st_d;

  logic [IDX_W-1:0] idx;
  logic [2:0] evt;
  logic wr_en;
  logic [15:0] wmask;
  logic [15:0] wdata;

  // Accepts a value only after INTEG_FRAMES identical frames in a row
  function automatic eorm_integ_t integ_step(eorm_integ_t s, logic [7:0] v);
    eorm_integ_t r;
    r = s;
    if (v == s.pres) begin
      r.cand = s.pres;
      r.cnt = 2'h0;
    end else if (v != s.cand || s.cnt == 2'h0) begin
      r.cand = v;
      r.cnt = 2'h1;
    end else if (s.cnt == INTEG_LAST) begin
      r.pres = v;
      r.cnt = 2'h0;
    end else begin
      r.cnt = s.cnt + 2'h1;
    end
    return r;
  endfunction

  // Saturating so a long interval never wraps to a small count
  function automatic logic [15:0] count_step(logic [15:0] acc, logic e);
    if (e && acc != COUNT_MAX) begin
      return acc + 16'h0001;
    end else begin
      return acc;
    end
  endfunction

  function automatic logic reg_hit(logic [IDX_W-1:0] i);
    if (i == IDX_LATCHED) begin
      return 1'b1;
    end else if (i == IDX_IRQ_EN2 || i == IDX_MA_INFO || i == IDX_NR_GC) begin
      return 1'b1;
    end else if (i == IDX_FRAME_CNT || i == IDX_PARITY_CNT) begin
      return 1'b1;
    end else if (i == IDX_REMOTE_CNT || i == IDX_CONTROL) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction

  function automatic logic [15:0] rd_word(eorm_state_t s, logic [IDX_W-1:0] i);
    logic [15:0] w;
    w = 16'h0000;
    if (i == IDX_LATCHED) begin
      w = s.latched & FLAG_MASK;
    end else if (i == IDX_IRQ_EN2) begin
      w = s.irq_en & FLAG_MASK;
    end else if (i == IDX_MA_INFO) begin
      w[PT_LSB +: 3] = s.pt.pres[2:0];
      w[3:0] = s.ti.pres[3:0];
    end else if (i == IDX_NR_GC) begin
      w[GC_LSB +: 8] = s.gc.pres;
      w[7:0] = s.nr.pres;
    end else if (i == IDX_FRAME_CNT) begin
      w = s.count[CNT_FRAME];
    end else if (i == IDX_PARITY_CNT) begin
      w = s.count[CNT_PARITY];
    end else if (i == IDX_REMOTE_CNT) begin
      w = s.count[CNT_REMOTE];
    end else if (i == IDX_CONTROL) begin
      w[BIT_TI_EXTRACT] = s.ti_extract_en;
    end
    return w;
  endfunction

  assign idx = paddr[APB_ADDR_W-1:2];
  assign evt = {remote_err_evt, parity_err_evt, frame_err_evt};
  // Zero-wait slave: every access phase completes in its first cycle
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite && !st_q.slverr;
  assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign wdata = pwdata[15:0];

  always_comb begin
    logic [15:0] set_bits;
    logic [15:0] clr_bits;
    logic [3:0] ti_word;
    st_d = st_q;
    set_bits = 16'h0000;
    clr_bits = 16'h0000;
    ti_word = 4'h0;

    // APB setup phase: decode and capture read data for the access phase
    if (psel && !penable) begin
      st_d.slverr = !reg_hit(idx) || (paddr[1:0] != 2'b00);
      st_d.rdata = {16'h0000, rd_word(st_q, idx)};
    end

    if (wr_en) begin
      if (idx == IDX_IRQ_EN2) begin
        st_d.irq_en = ((st_q.irq_en & ~wmask) | (wdata & wmask)) & FLAG_MASK;
      end else if (idx == IDX_LATCHED) begin
        clr_bits = wdata & wmask & FLAG_MASK;
      end else if (idx == IDX_CONTROL && pstrb[0]) begin
        st_d.ti_extract_en = wdata[BIT_TI_EXTRACT];
      end
    end

    set_bits[BIT_REMOTE_ERR] = remote_err_evt;
    set_bits[BIT_PARITY_ERR] = parity_err_evt;
    set_bits[BIT_FRAME_ERR] = frame_err_evt;

    // Counters: accumulate privately, publish only on the update strobe
    for (int k = 0; k < 3; k++) begin
      if (perf_monitor_update) begin
        st_d.count[k] = count_step(st_q.acc[k], evt[k]);
        st_d.acc[k] = COUNT_RST;
      end else begin
        st_d.acc[k] = count_step(st_q.acc[k], evt[k]);
      end
    end
    // Count status is "published count nonzero"; a rise sets the change flag
    if (perf_monitor_update) begin
      set_bits[BIT_FRAME_CNT] = (st_q.count[CNT_FRAME] == 16'h0000)
        && (st_d.count[CNT_FRAME] != 16'h0000);
      set_bits[BIT_PARITY_CNT] = (st_q.count[CNT_PARITY] == 16'h0000)
        && (st_d.count[CNT_PARITY] != 16'h0000);
      set_bits[BIT_REMOTE_CNT] = (st_q.count[CNT_REMOTE] == 16'h0000)
        && (st_d.count[CNT_REMOTE] != 16'h0000);
    end

    // A flag set in the same cycle as its clear stays set
    st_d.latched = ((st_q.latched & ~clr_bits) | set_bits) & FLAG_MASK;

    if (frame_valid) begin
      st_d.pt = integ_step(st_q.pt, {5'h00, ma_byte[MA_PT_LSB +: 3]});
      st_d.nr = integ_step(st_q.nr, nr_byte);
      st_d.gc = integ_step(st_q.gc, gc_byte);
      if (st_q.ti_extract_en) begin
        // MA[8] marks the first frame; MA[7] carries one timing bit per frame
        if (ma_byte[0]) begin
          st_d.ti_shift = {3'b000, ma_byte[1]};
          st_d.ti_phase = 2'h1;
        end else begin
          ti_word = {st_q.ti_shift[2:0], ma_byte[1]};
          st_d.ti_shift = ti_word;
          st_d.ti_phase = st_q.ti_phase + 2'h1;
          if (st_q.ti_phase == TI_LAST_PHASE) begin
            st_d.ti = integ_step(st_q.ti, {4'h0, ti_word});
          end
        end
      end else begin
        st_d.ti_phase = 2'h0;
        st_d.ti = integ_step(st_q.ti, {5'h00, ma_byte[2:0]});
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
      st_q.irq_en <= IRQ_EN_RST;
      st_q.latched <= LATCHED_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.rdata;
  assign pslverr = st_q.slverr;
  // Enable bit gates each flag; the port-level enable gates them all
  assign irq_req = global_port_irq_enable
    && |(st_q.latched & st_q.irq_en & FLAG_MASK);

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  irq_remote_a: assert property (
    st_q.latched[BIT_REMOTE_ERR] && st_q.irq_en[BIT_REMOTE_ERR]
    && global_port_irq_enable |-> irq_req)
    else $error("remote error interrupt not raised");
  irq_parity_a: assert property (
    st_q.latched[BIT_PARITY_ERR] && st_q.irq_en[BIT_PARITY_ERR]
    && global_port_irq_enable |-> irq_req)
    else $error("parity error interrupt not raised");
  irq_frame_a: assert property (
    st_q.latched[BIT_FRAME_ERR] && st_q.irq_en[BIT_FRAME_ERR]
    && global_port_irq_enable |-> irq_req)
    else $error("framing error interrupt not raised");
  irq_cnt_change_a: assert property (
    global_port_irq_enable && |(st_q.latched[2:0] & st_q.irq_en[2:0]) |-> irq_req)
    else $error("count change interrupt not raised");
  irq_port_gate_a: assert property (
    !global_port_irq_enable |-> !irq_req)
    else $error("interrupt raised with port disabled");
  irq_only_enabled_a: assert property (
    irq_req |-> |(st_q.latched & st_q.irq_en))
    else $error("interrupt raised with no enabled flag");
  remote_latch_a: assert property (
    remote_err_evt |=> st_q.latched[BIT_REMOTE_ERR])
    else $error("remote error flag not set");
  frame_latch_set_a: assert property (
    frame_err_evt ##1 !frame_err_evt [*2] |-> st_q.latched[BIT_FRAME_ERR]
    || $past(wr_en))
    else $error("framing error flag lost");
  count_hold_a: assert property (
    !perf_monitor_update |=> $stable(st_q.count))
    else $error("counter moved without update");
  count_load_a: assert property (
    perf_monitor_update && !frame_err_evt |=>
    st_q.count[CNT_FRAME] == $past(st_q.acc[CNT_FRAME]) && st_q.acc[CNT_FRAME] == 16'h0000
    || $past(frame_err_evt, 2))
    else $error("framing counter load wrong");
  nr_integrate_a: assert property (
    $changed(st_q.nr.pres) |-> $past(frame_valid) && $past(st_q.nr.cnt) == INTEG_LAST)
    else $error("NR accepted too early");
  nr_stable_a: assert property (
    !frame_valid |=> $stable(st_q.nr.pres))
    else $error("NR changed without a frame");
  ti_off_a: assert property (
    !st_q.ti_extract_en && frame_valid && st_q.ti.cnt == INTEG_LAST
    && st_q.ti.cand == {5'h00, ma_byte[2:0]} |=> st_q.ti.pres[3] == 1'b0)
    else $error("TI bit 3 set with extraction off");
  irq_parity_cnt_a: assert property (
    st_q.latched[BIT_PARITY_CNT] && st_q.irq_en[BIT_PARITY_CNT]
    && global_port_irq_enable |-> irq_req)
    else $error("parity count interrupt not raised");
  irq_frame_cnt_a: assert property (
    st_q.latched[BIT_FRAME_CNT] && st_q.irq_en[BIT_FRAME_CNT]
    && global_port_irq_enable |-> irq_req)
    else $error("framing count interrupt not raised");
  parity_latch_a: assert property (
    parity_err_evt |=> st_q.latched[BIT_PARITY_ERR])
    else $error("parity error flag not set");
  remote_hold_a: assert property (
    $fell(st_q.latched[BIT_REMOTE_ERR]) |-> $past(wr_en && idx == IDX_LATCHED))
    else $error("remote error flag dropped without a clear");
  cnt_flag_set_a: assert property (
    perf_monitor_update && st_q.count[CNT_FRAME] == 16'h0000
    && (st_q.acc[CNT_FRAME] != 16'h0000 || frame_err_evt) |=> st_q.latched[BIT_FRAME_CNT])
    else $error("framing count change flag not set");
  enable_write_a: assert property (
    wr_en && idx == IDX_IRQ_EN2 && pstrb[1:0] == 2'b11
    |=> st_q.irq_en == ($past(pwdata[15:0]) & FLAG_MASK))
    else $error("interrupt enable write lost");
  pt_view_a: assert property (
    psel && !penable && idx == IDX_MA_INFO |=> st_q.rdata[6:4] == $past(st_q.pt.pres[2:0]))
    else $error("payload type read wrong");
  ti_view_a: assert property (
    psel && !penable && idx == IDX_MA_INFO |=> st_q.rdata[3:0] == $past(st_q.ti.pres[3:0]))
    else $error("timing source read wrong");
  nr_gc_view_a: assert property (
    psel && !penable && idx == IDX_NR_GC
    |=> st_q.rdata[15:0] == {$past(st_q.gc.pres), $past(st_q.nr.pres)})
    else $error("NR GC read wrong");
  frame_cnt_view_a: assert property (
    psel && !penable && idx == IDX_FRAME_CNT
    |=> st_q.rdata[15:0] == $past(st_q.count[CNT_FRAME]))
    else $error("framing count read wrong");
  parity_cnt_view_a: assert property (
    psel && !penable && idx == IDX_PARITY_CNT
    |=> st_q.rdata[15:0] == $past(st_q.count[CNT_PARITY]))
    else $error("parity count read wrong");
  remote_cnt_view_a: assert property (
    psel && !penable && idx == IDX_REMOTE_CNT
    |=> st_q.rdata[15:0] == $past(st_q.count[CNT_REMOTE]))
    else $error("remote count read wrong");
  gc_stable_a: assert property (
    !frame_valid |=> $stable(st_q.gc.pres))
    else $error("GC changed without a frame");

  irq_seen_c: cover property (global_port_irq_enable ##1 irq_req);
  pmu_load_c: cover property (perf_monitor_update ##1 st_q.count[CNT_PARITY] != 16'h0000);
  nr_accept_c: cover property ($changed(st_q.nr.pres));
  set_clear_c: cover property (wr_en && idx == IDX_LATCHED && remote_err_evt);
  cnt_change_c: cover property (perf_monitor_update ##1 st_q.latched[BIT_FRAME_CNT]);

endmodule

// ===== verification/eorm_apb_host.sv
// APB host model that performs single register transfers into the bank.
// Assumes the bench calls xfer hierarchically, one transfer at a time.
`timescale 1ns/1ps
module eorm_apb_host
  import eorm_pkg::*;
(
  input wire logic ref_clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [APB_ADDR_W-1:0] paddr,
  output logic [DATA_W-1:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
  end

  // Released address and data lines carry inverted values so stale data never looks valid
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= 4'hf;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~wd;
    pstrb <= 4'h0;
  endtask
endmodule

// ===== verification/tb.sv
// Self-checking bench for the receive overhead monitor register bank.
// Assumes one 200 MHz clock; framer side is driven directly by the bench.
`timescale 1ns/1ps
module tb;
  import eorm_pkg::*;
  logic ref_clk, reset_n, psel, penable, pwrite, pready, pslverr, irq_req;
  logic [7:0] paddr, ma_byte, nr_byte, gc_byte;
  logic [31:0] pwdata, prdata, v;
  logic [3:0] pstrb, word;
  logic [2:0] evt;
  logic frame_valid, perf_monitor_update, global_port_irq_enable;
  logic [15:0] cnt [3];
  logic [5:0] idx [8] = '{IDX_LATCHED, IDX_IRQ_EN2, IDX_MA_INFO, IDX_NR_GC,
                          IDX_FRAME_CNT, IDX_PARITY_CNT, IDX_REMOTE_CNT, IDX_CONTROL};
  int errors, checks, seed, cyc, n;

  eorm_rx_ovh_regs DUT (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .frame_valid(frame_valid),
    .ma_byte(ma_byte), .nr_byte(nr_byte), .gc_byte(gc_byte), .frame_err_evt(evt[0]),
    .parity_err_evt(evt[1]), .remote_err_evt(evt[2]),
    .perf_monitor_update(perf_monitor_update),
    .global_port_irq_enable(global_port_irq_enable), .irq_req(irq_req));
  eorm_apb_host host (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  function automatic logic [7:0] ad(logic [5:0] i);
    return {i, 2'b00};
  endfunction

  task automatic end_sim();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e, logic ee, string nm);
    logic [31:0] d;
    logic er;
    host.xfer(1'b0, a, 32'h0000_0000, d, er);
    chk(nm, e, d);
    chk({nm, " slverr"}, {31'h0, ee}, {31'h0, er});
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] q;
    logic er;
    host.xfer(1'b1, a, d, q, er);
  endtask

  task automatic frame(logic [7:0] ma, logic [7:0] nr, logic [7:0] gc);
    @(posedge ref_clk);
    frame_valid <= 1'b1;
    ma_byte <= ma;
    nr_byte <= nr;
    gc_byte <= gc;
    @(posedge ref_clk);
    frame_valid <= 1'b0;
    ma_byte <= ~ma;
  endtask

  // Events for len cycles, all three in the first and random after; update rides with the last cycle's events
  task automatic burst(int len, logic upd);
    logic [2:0] e;
    for (int i = 0; i < len; i++) begin
      e = (i == 0) ? 3'h7 : 3'($random(seed));
      @(posedge ref_clk);
      evt <= e;
      perf_monitor_update <= upd && (i == len - 1);
      for (int t = 0; t < 3; t++) cnt[t] += 16'(e[t]);
    end
    @(posedge ref_clk);
    evt <= 3'h0;
    perf_monitor_update <= 1'b0;
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 20000) begin
      errors++;
      $display("ERROR timeout expected finish seen running");
      end_sim();
    end
  end

  initial begin
    seed = 57;
    reset_n = 1'b0;
    {frame_valid, perf_monitor_update, global_port_irq_enable, evt} = 6'h00;
    {ma_byte, nr_byte, gc_byte} = 24'h00_0000;
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    foreach (idx[i]) rd(ad(idx[i]), 32'h0000_0000, 1'b0, "reset value");
    rd(8'h00, 32'h0000_0000, 1'b1, "unmapped read");
    rd(ad(IDX_LATCHED) | 8'h01, 32'h0000_0000, 1'b1, "misaligned read");
    v = $random(seed);
    wr(ad(IDX_IRQ_EN2), v);
    rd(ad(IDX_IRQ_EN2), v & {16'h0, FLAG_MASK}, 1'b0, "irq enable rw");
    wr(ad(IDX_IRQ_EN2), 32'h0000_0000);
    $display("test reset and access done");
    cnt = '{16'h0, 16'h0, 16'h0};
    for (int r = 0; r < 2; r++) begin
      // Events of the held burst stay in the accumulator until the next update
      burst(20 + ($random(seed) & 15), 1'b1);
      rd(ad(IDX_FRAME_CNT), {16'h0, cnt[CNT_FRAME]}, 1'b0, "frame count");
      rd(ad(IDX_PARITY_CNT), {16'h0, cnt[CNT_PARITY]}, 1'b0, "parity count");
      rd(ad(IDX_REMOTE_CNT), {16'h0, cnt[CNT_REMOTE]}, 1'b0, "remote count");
      v = {16'h0, cnt[CNT_FRAME]};
      cnt = '{16'h0, 16'h0, 16'h0};
      burst(5, 1'b0);
      rd(ad(IDX_FRAME_CNT), v, 1'b0, "count held");
      rd(ad(IDX_LATCHED), (r == 0) ? 32'h0000_0707 : 32'h0000_0700, 1'b0, "flags");
      wr(ad(IDX_LATCHED), 32'h0000_ffff);
      rd(ad(IDX_LATCHED), 32'h0000_0000, 1'b0, "flags cleared");
    end
    $display("test counters done");
    for (int b = 0; b < 11; b++) begin
      if (FLAG_MASK[b]) begin
        repeat (2) burst(1, 1'b0);
        @(posedge ref_clk);
        perf_monitor_update <= 1'b1;
        @(posedge ref_clk);
        perf_monitor_update <= 1'b0;
        @(posedge ref_clk);
        perf_monitor_update <= 1'b1;
        @(posedge ref_clk);
        perf_monitor_update <= 1'b0;
        wr(ad(IDX_LATCHED), 32'h0000_ffff);
        @(posedge ref_clk);
        evt <= 3'(1 << (b & 7));
        perf_monitor_update <= 1'b1;
        @(posedge ref_clk);
        evt <= 3'h0;
        perf_monitor_update <= 1'b0;
        global_port_irq_enable <= 1'b1;
        wr(ad(IDX_IRQ_EN2), 32'(1 << b));
        @(posedge ref_clk);
        chk("irq pass", 32'h1, {31'h0, irq_req});
        global_port_irq_enable <= 1'b0;
        @(posedge ref_clk);
        @(posedge ref_clk);
        chk("irq port off", 32'h0, {31'h0, irq_req});
        global_port_irq_enable <= 1'b1;
        wr(ad(IDX_IRQ_EN2), {16'h0, FLAG_MASK & ~16'((1 << (b & 7)) | (1 << ((b & 7) + 8)))});
        @(posedge ref_clk);
        chk("irq blocked", 32'h0, {31'h0, irq_req});
        wr(ad(IDX_IRQ_EN2), 32'(1 << b));
        wr(ad(IDX_LATCHED), 32'(1 << b));
        @(posedge ref_clk);
        chk("irq cleared", 32'h0, {31'h0, irq_req});
      end
    end
    $display("test interrupts done");
    v = $random(seed) | 32'h0000_0001;
    for (int k = 1; k <= 3; k++) begin
      frame(v[23:16], v[7:0], v[15:8]);
      rd(ad(IDX_NR_GC), (k < 3) ? 32'h0 : {16'h0, v[15:0]}, 1'b0, "nr gc");
      rd(ad(IDX_MA_INFO), (k < 3) ? 32'h0 : {25'h0, v[21:19], 1'b0, v[18:16]}, 1'b0,
         "ma info");
    end
    wr(ad(IDX_CONTROL), 32'h0000_0001);
    word = 4'($random(seed));
    for (int m = 0; m < 4; m++)
      for (int i = 0; i < 4; i++) frame({2'b00, v[21:19], 1'b0, word[3-i], i == 0}, 8'h00,
                                         8'h00);
    rd(ad(IDX_MA_INFO), {25'h0, v[21:19], word}, 1'b0, "timing source");
    rd(ad(IDX_CONTROL), 32'h0000_0001, 1'b0, "control rw");
    $display("test overhead done");
    end_sim();
  end
endmodule
